/* src/sysreg_enable_vprio_access.v */
// Purpose: Access checks for interface-enable registers and virtual active priorities
// Assumes: Core presents one access per strobe; result is one cycle later
// Notes: Physical and level-1/level-2 register contents live outside this block
`timescale 1ns/1ps
`default_nettype none
`include "sysreg_access_defs.vh"

module sysreg_enable_vprio_access #(
    parameter integer HAVE_L3 = 1,
    parameter integer HAVE_L2 = 1,
    parameter integer NIRQ_BYPASS = 1,
    parameter integer FIRQ_BYPASS = 1,
    parameter integer SEL_FIXED_ONE = 0,
    parameter integer PRIO_BITS = 7
) (
    // Clock and reset
    input wire sys_clk_i,
    input wire sys_rst_i,
    // Access request from the core
    input wire acc_valid_i,
    input wire acc_write_i,
    input wire [1:0] acc_level_i,
    input wire acc_nonsecure_i,
    input wire [1:0] enc_op0_i,
    input wire [2:0] enc_op1_i,
    input wire [3:0] enc_crn_i,
    input wire [3:0] enc_crm_i,
    input wire [2:0] enc_op2_i,
    input wire [63:0] acc_wdata_i,
    // Configuration from the core
    input wire level2_enabled_i,
    input wire nested_virtualization_bit_i,
    input wire hyp_fast_irq_routing_i,
    input wire hyp_trap_all_group0_i,
    input wire monitor_fast_irq_routing_i,
    input wire level1_select_i,
    input wire level2_select_i,
    input wire level2_trap_enable_i,
    // Access result
    output reg acc_done_o,
    output reg [1:0] acc_outcome_o,
    output reg [1:0] acc_trap_level_o,
    output reg [5:0] acc_trap_class_o,
    output reg [63:0] acc_rdata_o,
    // Level-3 enable controls for the rest of the interface
    output reg l3_trap_enable_eff_o,
    output reg normal_irq_bypass_disable_o,
    output reg fast_irq_bypass_disable_o,
    output reg l3_interface_select_o
);
    reg [3:0] l3_r;
    wire is_l1en;
    wire is_l2en;
    wire l2_on;
    wire is_l3en;
    wire is_ap0;
    wire is_ap1;
    wire [`AP_WIDTH-1:0] ap0_rdata;
    wire [`AP_WIDTH-1:0] ap1_rdata;
    wire ap0_impl;
    wire ap1_impl;
    wire l3_present;
    wire trap_en_eff;
    wire [3:0] l3_view;
    reg [1:0] out_nxt;
    reg [1:0] lvl_nxt;
    reg [63:0] rd_nxt;
    reg ap0_wr;
    reg ap1_wr;
    reg l3_wr;

    assign l3_present = (HAVE_L3 != 0);
    // A core built without level 2 never reports it enabled, whatever the pin says
    assign l2_on = level2_enabled_i && (HAVE_L2 != 0);

    // Same decode serves physical and virtual copies; routing picks one
    assign is_l1en = enc_op0_i == `ENC_OP0 && enc_op1_i == `L1EN_OP1 &&
        enc_crn_i == `ENC_CRN && enc_crm_i == `L1EN_CRM && enc_op2_i == `L1EN_OP2;
    assign is_l2en = enc_op0_i == `ENC_OP0 && enc_op1_i == `L2EN_OP1 &&
        enc_crn_i == `ENC_CRN && enc_crm_i == `L2EN_CRM && enc_op2_i == `L2EN_OP2;
    assign is_l3en = enc_op0_i == `ENC_OP0 && enc_op1_i == `L3EN_OP1 &&
        enc_crn_i == `ENC_CRN && enc_crm_i == `L3EN_CRM && enc_op2_i == `L3EN_OP2;
    assign is_ap0 = enc_op0_i == `ENC_OP0 && enc_op1_i == `AP_OP1 &&
        enc_crn_i == `ENC_CRN && enc_crm_i == `AP0_CRM && enc_op2_i[2];
    assign is_ap1 = enc_op0_i == `ENC_OP0 && enc_op1_i == `AP_OP1 &&
        enc_crn_i == `ENC_CRN && enc_crm_i == `AP1_CRM && !enc_op2_i[2];

    // Select clear forces trap-enable to act as one; fixed-one option ties both
    assign trap_en_eff = l3_r[`L3_TRAPEN_BIT] || !l3_r[`L3_SEL_BIT] ||
        (SEL_FIXED_ONE != 0);

    // Read view: reserved bits 63..4 come back as zero
    assign l3_view = {l3_r[`L3_TRAPEN_BIT] | (SEL_FIXED_ONE != 0),
        l3_r[`L3_NIBD_BIT] | (NIRQ_BYPASS == 0),
        l3_r[`L3_FIBD_BIT] | (FIRQ_BYPASS == 0),
        l3_r[`L3_SEL_BIT] | (SEL_FIXED_ONE != 0)};

    active_prio_bank #(.PRIO_BITS(PRIO_BITS)) u_ap0 (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .wr_i(ap0_wr),
        .idx_i(enc_op2_i[1:0]),
        .wdata_i(acc_wdata_i[`AP_WIDTH-1:0]),
        .rdata_o(ap0_rdata),
        .impl_o(ap0_impl)
    );

    active_prio_bank #(.PRIO_BITS(PRIO_BITS)) u_ap1 (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .wr_i(ap1_wr),
        .idx_i(enc_op2_i[1:0]),
        .wdata_i(acc_wdata_i[`AP_WIDTH-1:0]),
        .rdata_o(ap1_rdata),
        .impl_o(ap1_impl)
    );

    // Group 1 words are reached only through the virtual route at non-secure level 1
    always @* begin
        out_nxt = `OUT_UNDEF;
        lvl_nxt = `LVL0;
        rd_nxt = 64'h0;
        ap0_wr = 1'b0;
        ap1_wr = 1'b0;
        l3_wr = 1'b0;
        if (is_l2en) begin
            case (acc_level_i)
                `LVL1: begin
                    if (l2_on && nested_virtualization_bit_i) begin
                        out_nxt = `OUT_TRAP;
                        lvl_nxt = `LVL2;
                    end
                end
                `LVL2: begin
                    if (l3_present && !trap_en_eff) begin
                        out_nxt = `OUT_TRAP;
                        lvl_nxt = `LVL3;
                    end else begin
                        out_nxt = `OUT_OK;
                    end
                end
                `LVL3: begin
                    if (l2_on) begin
                        out_nxt = `OUT_OK;
                    end
                end
                default: out_nxt = `OUT_UNDEF;
            endcase
        end else if (is_l1en) begin
            // Register contents live outside; only the routing is decided here
            case (acc_level_i)
                `LVL1: begin
                    // The level-2 gate is checked first so its trap wins over level 3
                    if (l2_on && !level2_trap_enable_i) begin
                        out_nxt = `OUT_TRAP;
                        lvl_nxt = `LVL2;
                    end else if (l3_present && !trap_en_eff) begin
                        out_nxt = `OUT_TRAP;
                        lvl_nxt = `LVL3;
                    end else begin
                        out_nxt = `OUT_OK;
                    end
                end
                `LVL2: begin
                    // Level 2 answers only to the level-3 gate
                    if (l3_present && !trap_en_eff) begin
                        out_nxt = `OUT_TRAP;
                        lvl_nxt = `LVL3;
                    end else begin
                        out_nxt = `OUT_OK;
                    end
                end
                `LVL3: out_nxt = `OUT_OK;
                default: out_nxt = `OUT_UNDEF;
            endcase
        end else if (is_l3en) begin
            // Only level 3 may touch it, and only if level 3 exists
            if (l3_present && acc_level_i == `LVL3) begin
                out_nxt = `OUT_OK;
                rd_nxt = {60'h0, l3_view};
                l3_wr = acc_write_i;
            end
        end else if (is_ap0) begin
            case (acc_level_i)
                `LVL1: begin
                    if (!level1_select_i) begin
                        out_nxt = `OUT_TRAP;
                        lvl_nxt = `LVL1;
                    end else if (l2_on && hyp_trap_all_group0_i) begin
                        out_nxt = `OUT_TRAP;
                        lvl_nxt = `LVL2;
                    end else if (l2_on && hyp_fast_irq_routing_i &&
                                 acc_nonsecure_i) begin
                        if (ap0_impl) begin
                            out_nxt = `OUT_OK;
                            rd_nxt = {32'h0, ap0_rdata};
                            ap0_wr = acc_write_i;
                        end
                    end else if (l3_present && monitor_fast_irq_routing_i) begin
                        out_nxt = `OUT_TRAP;
                        lvl_nxt = `LVL3;
                    end else begin
                        // Physical copy lives outside this block
                        out_nxt = `OUT_OK;
                    end
                end
                `LVL2: begin
                    if (!level2_select_i) begin
                        out_nxt = `OUT_TRAP;
                        lvl_nxt = `LVL2;
                    end else if (l3_present && monitor_fast_irq_routing_i) begin
                        out_nxt = `OUT_TRAP;
                        lvl_nxt = `LVL3;
                    end else begin
                        out_nxt = `OUT_OK;
                    end
                end
                `LVL3: begin
                    if (!(l3_r[`L3_SEL_BIT] || SEL_FIXED_ONE != 0)) begin
                        out_nxt = `OUT_TRAP;
                        lvl_nxt = `LVL3;
                    end else begin
                        out_nxt = `OUT_OK;
                    end
                end
                default: out_nxt = `OUT_UNDEF;
            endcase
        end else if (is_ap1) begin
            if (acc_level_i == `LVL1 && acc_nonsecure_i && l2_on &&
                level1_select_i && ap1_impl) begin
                out_nxt = `OUT_OK;
                rd_nxt = {32'h0, ap1_rdata};
                ap1_wr = acc_write_i;
            end
        end
        if (!acc_valid_i) begin
            ap0_wr = 1'b0;
            ap1_wr = 1'b0;
            l3_wr = 1'b0;
        end
    end

    // Level-3 enable register; unsupported bypass bits ignore writes
    always @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            l3_r <= `L3_RESET;
        end else if (l3_wr) begin
            l3_r[`L3_TRAPEN_BIT] <= acc_wdata_i[`L3_TRAPEN_BIT];
            l3_r[`L3_NIBD_BIT] <= acc_wdata_i[`L3_NIBD_BIT] & (NIRQ_BYPASS != 0);
            l3_r[`L3_FIBD_BIT] <= acc_wdata_i[`L3_FIBD_BIT] & (FIRQ_BYPASS != 0);
            // Clearing select after setting it is left to software discipline
            l3_r[`L3_SEL_BIT] <= acc_wdata_i[`L3_SEL_BIT];
        end
    end

    // Registered result and control outputs
    always @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            acc_done_o <= 1'b0;
            acc_outcome_o <= `OUT_OK;
            acc_trap_level_o <= `LVL0;
            acc_trap_class_o <= 6'h0;
            acc_rdata_o <= 64'h0;
            l3_trap_enable_eff_o <= 1'b1;
            normal_irq_bypass_disable_o <= 1'b0;
            fast_irq_bypass_disable_o <= 1'b0;
            l3_interface_select_o <= 1'b0;
        end else begin
            acc_done_o <= acc_valid_i;
            if (acc_valid_i) begin
                acc_outcome_o <= out_nxt;
                acc_trap_level_o <= lvl_nxt;
                acc_trap_class_o <= (out_nxt == `OUT_TRAP) ? `TRAP_CLASS : 6'h0;
                acc_rdata_o <= (out_nxt == `OUT_OK && !acc_write_i) ? rd_nxt : 64'h0;
            end
            l3_trap_enable_eff_o <= trap_en_eff;
            normal_irq_bypass_disable_o <= l3_view[`L3_NIBD_BIT];
            fast_irq_bypass_disable_o <= l3_view[`L3_FIBD_BIT];
            l3_interface_select_o <= l3_view[`L3_SEL_BIT];
        end
    end
endmodule // sysreg_enable_vprio_access
`default_nettype wire

/* shared/sysreg_access_defs.vh */
// Purpose: Constants for the interface-enable and virtual active-priority register block
// Assumes: Included by the design files of this block only
// Notes: Encodings are the system-register instruction fields op0/op1/CRn/CRm/op2
`ifndef SYSREG_ACCESS_DEFS_VH
`define SYSREG_ACCESS_DEFS_VH

// Outcome codes
`define OUT_OK 2'h0
`define OUT_UNDEF 2'h1
`define OUT_TRAP 2'h2

// Trap class for all system register traps
`define TRAP_CLASS 6'h18

// Privilege levels
`define LVL0 2'h0
`define LVL1 2'h1
`define LVL2 2'h2
`define LVL3 2'h3

// Common encoding fields
`define ENC_OP0 2'h3
`define ENC_CRN 4'hc

// Level-2 enable register encoding
`define L2EN_OP1 3'h4
`define L2EN_CRM 4'h9
`define L2EN_OP2 3'h5

// Level-1 enable register encoding
`define L1EN_OP1 3'h0
`define L1EN_CRM 4'hc
`define L1EN_OP2 3'h5

// Level-3 enable register encoding
`define L3EN_OP1 3'h6
`define L3EN_CRM 4'hc
`define L3EN_OP2 3'h5

// Active-priority encodings (op1 0, op2 = g0 ? 1:n : 0:n)
`define AP_OP1 3'h0
`define AP0_CRM 4'h8
`define AP1_CRM 4'h9

// Level-3 enable register fields
`define L3_TRAPEN_BIT 3
`define L3_NIBD_BIT 2
`define L3_FIBD_BIT 1
`define L3_SEL_BIT 0
`define L3_RESET 4'h0

// Level-2 enable register fields
`define L2_TRAPEN_BIT 3
`define L2_SEL_BIT 0

// Active-priority data width
`define AP_WIDTH 32

`endif

/* src/active_prio_bank.v */
// Purpose: Four 32-bit active-priority words with implemented-count gating
// Assumes: Write strobe is qualified by the access checker
// Notes: Words beyond the implemented count never store and read zero
`timescale 1ns/1ps
`default_nettype none
`include "sysreg_access_defs.vh"

module active_prio_bank #(
    parameter integer PRIO_BITS = 5
) (
    // Clock and reset
    input wire sys_clk_i,
    input wire sys_rst_i,
    // Access
    input wire wr_i,
    input wire [1:0] idx_i,
    input wire [`AP_WIDTH-1:0] wdata_i,
    // Results
    output wire [`AP_WIDTH-1:0] rdata_o,
    output wire impl_o
);
    reg [`AP_WIDTH-1:0] word_r [0:3];
    wire [3:0] impl_w;

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_word
            // Word 1 needs 6 priority bits, words 2 and 3 need 7
            assign impl_w[g] = (g == 0) ? 1'b1 : (g == 1) ? (PRIO_BITS >= 6) :
                (PRIO_BITS >= 7);
            // Reset to zero, a legal form of the unknown reset value: no active interrupts
            always @(posedge sys_clk_i or posedge sys_rst_i) begin
                if (sys_rst_i) begin
                    word_r[g] <= {`AP_WIDTH{1'b0}};
                end else if (wr_i && idx_i == g && impl_w[g]) begin
                    word_r[g] <= wdata_i;
                end
            end
        end
    endgenerate

    assign impl_o = impl_w[idx_i];
    assign rdata_o = impl_w[idx_i] ? word_r[idx_i] : {`AP_WIDTH{1'b0}};
endmodule // active_prio_bank
`default_nettype wire

/* tb/sysreg_enable_vprio_access_monitor.sv */
// Purpose: Port-level checks of access outcomes for the enable and priority block
// Assumes: One access per strobe, outcome one cycle later
// Notes: Antecedents read config at the strobe edge; outcomes land on the next edge
`timescale 1ns/1ps
`default_nettype none
module sysreg_enable_vprio_access_monitor (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    // Request and configuration
    input wire logic acc_valid_i,
    input wire logic [1:0] acc_level_i,
    input wire logic [2:0] enc_op1_i,
    input wire logic [3:0] enc_crm_i,
    input wire logic [2:0] enc_op2_i,
    input wire logic level2_enabled_i,
    input wire logic nested_virtualization_bit_i,
    // Results
    input wire logic [1:0] acc_outcome_o,
    input wire logic [1:0] acc_trap_level_o,
    input wire logic [5:0] acc_trap_class_o,
    input wire logic [63:0] acc_rdata_o,
    input wire logic l3_trap_enable_eff_o,
    input wire logic l3_interface_select_o,
    input wire logic acc_done_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);
    sequence l2_req;
        acc_valid_i && enc_op1_i == 3'h4 && enc_crm_i == 4'h9 && enc_op2_i == 3'h5;
    endsequence
    sequence l3_req;
        acc_valid_i && enc_op1_i == 3'h6 && enc_crm_i == 4'hc && enc_op2_i == 3'h5;
    endsequence
    el0_undefined_a: assert property (acc_valid_i && acc_level_i == 2'h0 |=>
        acc_outcome_o == 2'h1) else $error("level 0 access not undefined");
    l3_lower_undef_a: assert property (l3_req ##0 acc_level_i != 2'h3 |=>
        acc_outcome_o == 2'h1) else $error("lower level reached level-3 enable");
    l3_reserved_zero_a: assert property (l3_req ##0 acc_level_i == 2'h3 |=>
        acc_rdata_o[63:4] == 60'h0) else $error("reserved enable bits not zero");
    nested_trap_a: assert property (l2_req ##0 (acc_level_i == 2'h1 &&
        level2_enabled_i && nested_virtualization_bit_i) |=> acc_outcome_o == 2'h2 &&
        acc_trap_level_o == 2'h2) else $error("nested access not trapped to 2");
    nested_undef_a: assert property (l2_req ##0 (acc_level_i == 2'h1 &&
        !(level2_enabled_i && nested_virtualization_bit_i)) |=> acc_outcome_o == 2'h1)
        else $error("level 1 access not undefined");
    l2_trap_l3_a: assert property (l2_req ##0 (acc_level_i == 2'h2 &&
        !l3_trap_enable_eff_o) |=> acc_outcome_o == 2'h2 && acc_trap_level_o == 2'h3)
        else $error("level 2 access not trapped to 3");
    l3_needs_l2_a: assert property (l2_req ##0 acc_level_i == 2'h3 |=>
        acc_outcome_o == ($past(level2_enabled_i) ? 2'h0 : 2'h1))
        else $error("level 3 access ignores level 2 enable");
    trap_class_a: assert property (acc_done_o && acc_outcome_o == 2'h2 |->
        acc_trap_class_o == 6'h18) else $error("wrong trap class");
    sel_idle_trap_a: assert property (acc_valid_i && acc_level_i == 2'h3 &&
        enc_op1_i == 3'h0 && enc_crm_i == 4'h8 && enc_op2_i[2] && !l3_interface_select_o |=>
        acc_outcome_o == 2'h2 && acc_trap_level_o == 2'h3) else $error("no select trap");
endmodule // sysreg_enable_vprio_access_monitor
bind sysreg_enable_vprio_access sysreg_enable_vprio_access_monitor chk_mon (.sys_clk_i,
    .sys_rst_i, .acc_valid_i, .acc_level_i, .enc_op1_i, .enc_crm_i, .enc_op2_i,
    .level2_enabled_i, .nested_virtualization_bit_i, .acc_outcome_o, .acc_trap_level_o,
    .acc_trap_class_o, .acc_rdata_o, .l3_trap_enable_eff_o, .l3_interface_select_o,
    .acc_done_o);
`default_nettype wire

/* tb/core_access_model.sv */
// Purpose: Processor core model issuing system register accesses
// Assumes: Fields change at the falling edge, one strobe per access
// Notes: Idle write data is inverted so a stale value never passes for live data
`timescale 1ns/1ps
`default_nettype none
module core_access_model (
    // Clock
    input wire logic sys_clk_i,
    // Request
    output logic acc_valid_o = 1'b0,
    output logic acc_write_o = 1'b0,
    output logic [1:0] acc_level_o = 2'h0,
    output logic [1:0] enc_op0_o = 2'h3,
    output logic [2:0] enc_op1_o = 3'h0,
    output logic [3:0] enc_crn_o = 4'hc,
    output logic [3:0] enc_crm_o = 4'h0,
    output logic [2:0] enc_op2_o = 3'h0,
    output logic [63:0] acc_wdata_o = 64'h0
);
    task automatic acc(input logic wr, input logic [1:0] l, input logic [2:0] o1,
        input logic [3:0] cm, input logic [2:0] o2, input logic [63:0] d);
        @(negedge sys_clk_i);
        {acc_valid_o, acc_write_o, acc_level_o} = {1'b1, wr, l};
        {enc_op1_o, enc_crm_o, enc_op2_o} = {o1, cm, o2};
        acc_wdata_o = d;
        @(negedge sys_clk_i);
        acc_valid_o = 1'b0;
        acc_wdata_o = ~d;
    endtask
endmodule // core_access_model
`default_nettype wire

/* tb/sysreg_enable_vprio_access_tb_top.sv */
// Purpose: Self-checking bench for the enable and active-priority access block
// Assumes: Each access is checked at the falling edge after its answer
// Notes: Priority depth 6, so words 2 and 3 are unimplemented
`timescale 1ns/1ps
`default_nettype none
module sysreg_enable_vprio_access_tb_top;
    localparam logic [1:0] ok = 2'h0, ud = 2'h1, tp = 2'h2;
    logic sys_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic l2en = 1'b1, nv = 1'b0, hyp_fast_irq_routing = 1'b0, hyp_trap_all_group0 = 1'b0, smon = 1'b0;
    logic s1 = 1'b0, s2 = 1'b0, ns = 1'b1, l2te = 1'b0;
    logic [31:0] d;
    wire v, w, done, eff, nbd, fbd, sel;
    wire [1:0] lvl, op0, oc, tl;
    wire [2:0] op1, op2;
    wire [3:0] crn, crm;
    wire [5:0] cls;
    wire [63:0] wd, rd;
    int n_fail = 0;
    int checks = 0;
    always #2 sys_clk_i = ~sys_clk_i;
    core_access_model core (.sys_clk_i(sys_clk_i), .acc_valid_o(v), .acc_write_o(w),
        .acc_level_o(lvl), .enc_op0_o(op0), .enc_op1_o(op1), .enc_crn_o(crn),
        .enc_crm_o(crm), .enc_op2_o(op2), .acc_wdata_o(wd));
    sysreg_enable_vprio_access #(.PRIO_BITS(6)) uut (.sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i), .acc_valid_i(v), .acc_write_i(w), .acc_level_i(lvl),
        .acc_nonsecure_i(ns), .enc_op0_i(op0), .enc_op1_i(op1), .enc_crn_i(crn),
        .enc_crm_i(crm), .enc_op2_i(op2), .acc_wdata_i(wd), .level2_enabled_i(l2en),
        .nested_virtualization_bit_i(nv), .hyp_fast_irq_routing_i(hyp_fast_irq_routing),
        .hyp_trap_all_group0_i(hyp_trap_all_group0), .monitor_fast_irq_routing_i(smon),
        .level1_select_i(s1), .level2_select_i(s2), .level2_trap_enable_i(l2te),
        .acc_done_o(done), .acc_outcome_o(oc), .acc_trap_level_o(tl),
        .acc_trap_class_o(cls), .acc_rdata_o(rd), .l3_trap_enable_eff_o(eff),
        .normal_irq_bypass_disable_o(nbd), .fast_irq_bypass_disable_o(fbd),
        .l3_interface_select_o(sel));
    task automatic chk(input logic [74:0] seen, input logic [74:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic go(input logic wr, input logic [1:0] l, input logic [2:0] o1,
        input logic [3:0] cm, input logic [2:0] o2, input logic [63:0] dd,
        input logic [1:0] eo, input logic [1:0] el, input logic [63:0] er);
        core.acc(wr, l, o1, cm, o2, dd);
        chk({done, oc, tl, cls, rd}, {1'b1, eo, el, (eo == tp) ? 6'h18 : 6'h0, er});
    endtask
    task automatic l2(input logic [1:0] l, input logic [1:0] eo, input logic [1:0] el);
        go(1'b0, l, 3'h4, 4'h9, 3'h5, 64'h0, eo, el, 64'h0);
    endtask
    task automatic l1(input logic [1:0] l, input logic [1:0] eo, input logic [1:0] el);
        go(1'b0, l, 3'h0, 4'hc, 3'h5, 64'h0, eo, el, 64'h0);
    endtask
    task automatic l3(input logic wr, input logic [1:0] l, input logic [63:0] dd,
        input logic [1:0] eo, input logic [63:0] er);
        go(wr, l, 3'h6, 4'hc, 3'h5, dd, eo, 2'h0, er);
    endtask
    task automatic ap(input logic g0, input logic wr, input logic [1:0] l,
        input logic [1:0] n, input logic [63:0] dd, input logic [1:0] eo,
        input logic [1:0] el, input logic [63:0] er);
        go(wr, l, 3'h0, g0 ? 4'h8 : 4'h9, {g0, n}, dd, eo, el, er);
    endtask
    task automatic stop_test();
        if (n_fail == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Some 47 accesses of two cycles each; the limit leaves a wide margin
    initial begin
        #20000;
        n_fail++;
        stop_test();
    end
    initial begin
        repeat (16) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        sys_rst_i = 1'b0;
        chk(75'({eff, nbd, fbd, sel}), 75'h8);
        l3(1'b0, 2'h3, 64'h0, ok, 64'h0);
        for (int i = 0; i < 3; i++) l3(1'b1, i[1:0], '1, ud, 64'h0);
        l3(1'b0, 2'h3, 64'h0, ok, 64'h0);
        l2(2'h0, ud, 2'h0);
        l2(2'h1, ud, 2'h0);
        nv = 1'b1;
        l2(2'h1, tp, 2'h2);
        l2en = 1'b0;
        l2(2'h1, ud, 2'h0);
        l2(2'h3, ud, 2'h0);
        l2en = 1'b1;
        l2(2'h3, ok, 2'h0);
        l2(2'h2, ok, 2'h0);
        l3(1'b1, 2'h3, 64'hffff_ffff_ffff_fff6, ok, 64'h0);
        l3(1'b0, 2'h3, 64'h0, ok, 64'h6);
        chk(75'({eff, nbd, fbd, sel}), 75'he);
        ap(1'b1, 1'b0, 2'h3, 2'h0, 64'h0, tp, 2'h3, 64'h0);
        // Select is set here and stays set until the mid-run reset clears it
        l3(1'b1, 2'h3, 64'h7, ok, 64'h0);
        l2(2'h2, tp, 2'h3);
        chk(75'({eff, nbd, fbd, sel}), 75'h7);
        l1(2'h1, tp, 2'h2);
        l2te = 1'b1;
        l1(2'h1, tp, 2'h3);
        l1(2'h2, tp, 2'h3);
        l3(1'b1, 2'h3, 64'hf, ok, 64'h0);
        l2(2'h2, ok, 2'h0);
        l1(2'h1, ok, 2'h0);
        l1(2'h2, ok, 2'h0);
        ap(1'b1, 1'b0, 2'h3, 2'h0, 64'h0, ok, 2'h0, 64'h0);
        ap(1'b1, 1'b0, 2'h2, 2'h0, 64'h0, tp, 2'h2, 64'h0);
        s2 = 1'b1;
        smon = 1'b1;
        ap(1'b1, 1'b0, 2'h2, 2'h0, 64'h0, tp, 2'h3, 64'h0);
        smon = 1'b0;
        ap(1'b1, 1'b0, 2'h2, 2'h0, 64'h0, ok, 2'h0, 64'h0);
        ap(1'b1, 1'b0, 2'h1, 2'h0, 64'h0, tp, 2'h1, 64'h0);
        s1 = 1'b1;
        hyp_trap_all_group0 = 1'b1;
        ap(1'b1, 1'b0, 2'h1, 2'h0, 64'h0, tp, 2'h2, 64'h0);
        hyp_trap_all_group0 = 1'b0;
        hyp_fast_irq_routing = 1'b1;
        // Group 0 words 0 and 1 are restored before any group 1 word; words 2 and 3 answer undefined
        for (int i = 0; i < 4; i++) begin
            d = 32'h1111_1111 * (i + 1);
            ap(1'b1, 1'b1, 2'h1, i[1:0], {32'hffff_ffff, d}, i < 2 ? ok : ud, 2'h0, 64'h0);
            ap(1'b1, 1'b0, 2'h1, i[1:0], 64'h0, i < 2 ? ok : ud, 2'h0,
                i < 2 ? {32'h0, d} : 64'h0);
        end
        ap(1'b1, 1'b1, 2'h1, 2'h0, 64'h0, ok, 2'h0, 64'h0);
        ap(1'b1, 1'b0, 2'h1, 2'h0, 64'h0, ok, 2'h0, 64'h0);
        ap(1'b0, 1'b1, 2'h1, 2'h0, 64'h5a5a, ok, 2'h0, 64'h0);
        ap(1'b0, 1'b0, 2'h1, 2'h0, 64'h0, ok, 2'h0, 64'h5a5a);
        ns = 1'b0;
        ap(1'b0, 1'b0, 2'h1, 2'h0, 64'h0, ud, 2'h0, 64'h0);
        ns = 1'b1;
        hyp_fast_irq_routing = 1'b0;
        smon = 1'b1;
        ap(1'b1, 1'b0, 2'h1, 2'h0, 64'h0, tp, 2'h3, 64'h0);
        smon = 1'b0;
        ap(1'b1, 1'b0, 2'h1, 2'h0, 64'h0, ok, 2'h0, 64'h0);
        // Reset in mid-run must bring the enable bits and group 0 priority word 1 back to zero
        sys_rst_i = 1'b1;
        repeat (2) @(negedge sys_clk_i);
        sys_rst_i = 1'b0;
        chk(75'({eff, nbd, fbd, sel}), 75'h8);
        l3(1'b0, 2'h3, 64'h0, ok, 64'h0);
        hyp_fast_irq_routing = 1'b1;
        ap(1'b1, 1'b0, 2'h1, 2'h1, 64'h0, ok, 2'h0, 64'h0);
        stop_test();
    end
endmodule // sysreg_enable_vprio_access_tb_top
`default_nettype wire
